/* File: hdl/cq_irq_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the
//          completion-queue interrupt block.
// Assumes: AXI4-Lite, 32-bit data, byte addresses.
// Notes:   Definitions only.
`ifndef CQ_IRQ_MAP_SVH
`define CQ_IRQ_MAP_SVH

`define OFS_MASK_SET      8'h00
`define OFS_MASK_CLEAR    8'h04
`define OFS_MODE_CTRL     8'h08
`define OFS_CQ_ENABLE     8'h0c
`define OFS_STATUS        8'h10
`define OFS_COAL          8'h14
`define OFS_QCOUNT        8'h18
`define OFS_SQ_DELETE     8'h1c
`define OFS_CQ_VEC_BASE   8'h40

`define BIT_MSI_ENABLE    0
`define BIT_MSIX_ENABLE   1
`define POS_MME_LO        4
`define POS_MME_HI        6
`define POS_MODE_LO       8
`define POS_MODE_HI       9
`define BIT_SQ_DEL_DONE   31

`define RST_MASK          32'h0000_0000
`define RST_MODE_CTRL     32'h0000_0000
`define RST_COAL          32'h0000_0000

`define MSG_BUSY_CYCLES   4
`endif

/* File: hdl/cq_irq_pkg.sv */
// Purpose: Types shared by the completion-queue interrupt block.
// Assumes: Used together with cq_irq_map.svh.
// Notes:   Types only; numbers live in the map header.
package cq_irq_pkg;

  typedef enum logic [1:0] {
    MODE_PIN    = 2'b00,
    MODE_MSI1   = 2'b01,
    MODE_MSIM   = 2'b10,
    MODE_MSIX   = 2'b11
  } irq_mode_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  vector;
  } msg_req_t;

  typedef struct packed {
    logic        req;
    logic [15:0] sq_granted;
    logic [15:0] cq_granted;
  } qcount_t;

endpackage

/* File: hdl/vector_status.sv */
// Purpose: Per-vector hidden status and message event detection.
// Assumes: Inputs are on ref_clk.
// Notes:   One generate slice per vector.
`timescale 1ns/1ps
`include "cq_irq_map.svh"
module vector_status #(
  parameter int NVEC = 32
) (
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire logic [NVEC-1:0] cq_pending,
  input  wire logic [NVEC-1:0] vec_irq_en,
  input  wire logic [NVEC-1:0] vec_mask,
  input  wire logic [NVEC-1:0] vec_live,
  output logic      [NVEC-1:0] status_reg,
  output logic      [NVEC-1:0] event_pulse
);
  initial begin
    if (NVEC < 1 || NVEC > 32) $error("NVEC must be 1..32");
  end

  logic [NVEC-1:0] mask_d_reg;

  genvar g;
  generate
    for (g = 0; g < NVEC; g++) begin : g_vec
      logic status_next;
      assign status_next = vec_live[g] & cq_pending[g] & vec_irq_en[g] & ~vec_mask[g];
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          status_reg[g] <= 1'b0;
          mask_d_reg[g] <= 1'b0;
        end else begin
          status_reg[g] <= status_next;
          mask_d_reg[g] <= vec_mask[g];
        end
      end
      // Rising edge of status, or unmask while pending work is already present
      assign event_pulse[g] = (status_next & ~status_reg[g])
                            | (mask_d_reg[g] & ~vec_mask[g] & status_next);
    end
  endgenerate
endmodule

/* File: hdl/msg_queue.sv */
// Purpose: Holds one pending message request per vector and issues them.
// Assumes: Message port takes a request in any cycle where msg_ready is high with msg_valid.
// Notes:   A pending bit merges repeated events on one vector while busy.
`timescale 1ns/1ps
`include "cq_irq_map.svh"
module msg_queue #(
  parameter int NVEC = 32
) (
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire logic [NVEC-1:0] event_pulse,
  input  wire logic [NVEC-1:0] still_set,
  input  wire logic            msg_mode,
  input  wire logic            msg_ready,
  output logic                 msg_valid_reg,
  output logic [4:0]           msg_vector_reg
);
  initial begin
    if (NVEC < 1 || NVEC > 32) $error("NVEC must be 1..32");
  end

  logic [NVEC-1:0] pend_reg;
  logic [NVEC-1:0] pend_next;
  logic            found;
  logic [4:0]      pick;
  logic            take;

  assign take = msg_valid_reg & msg_ready;

  always_comb begin
    found = 1'b0;
    pick  = 5'h00;
    for (int i = NVEC - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        found = 1'b1;
        pick  = 5'(i);
      end
    end
  end

  // Set beats clear; drop requests whose status already fell
  always_comb begin
    pend_next = pend_reg & still_set;
    if (take) begin
      pend_next[msg_vector_reg] = 1'b0;
    end
    pend_next = msg_mode ? (pend_next | event_pulse) : '0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_valid_reg  <= 1'b0;
      msg_vector_reg <= 5'h00;
    end else if (!msg_valid_reg || take) begin
      msg_valid_reg  <= found & ~take & msg_mode;
      msg_vector_reg <= pick;
    end
  end
endmodule

/* File: hdl/cq_irq_ctrl.sv */
// Purpose: Completion-queue interrupt controller for pin, single MSI and
//          multiple MSI modes, with an AXI4-Lite register slave.
// Assumes: Queue engine supplies per-vector pending and enable levels on
//          ref_clk; PCIe core consumes the wire level and message requests.
// Notes:   Coalescing values are stored and read back but not applied.
//
// Summary of operation
// - Exactly one of pin, single MSI, multiple MSI or MSI-X modes is active.
// - MSI off and MSI-X off selects pin-based behaviour.
// - MSI on, multi-message field zero, MSI-X off selects single MSI.
// - MSI on, multi-message field one, MSI-X off selects multiple MSI.
// - A hidden per-vector status vector alone decides wire or message; here it is readable at OFS_STATUS.
// - Status bit set only with pending entries, queue irq enabled, vector unmasked.
// - Mask is applied before message logic; masked vectors never pend.
// - With MSI off, wire is driven low while status bit zero is one.
// - MSI sends one message per unmasked rising status bit or unmask-while-set.
// - Partial acknowledgement keeps wire active or sends a new message.
// - All status bits zero releases the wire and sends no message.
// - Admin completion queue interrupts are never delayed.
// - Aggregation threshold is advisory only.
// - Aggregation time is advisory, per vector or global.
// - Coalescing parameters are accepted and read back but unused.
// - Granted queue counts are reported for the queue-count request.
// - SQ deletion reported only after all its commands finish or abort.
// - Mask bit index equals vector; set and clear registers are write-one.
// - Pin and single MSI use one vector; multiple MSI up to thirty-two.
`timescale 1ns/1ps
`include "cq_irq_map.svh"
module cq_irq_ctrl
  import cq_irq_pkg::*;
#(
  parameter int NVEC = 32
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [NVEC-1:0]    cq_pending,
  input  wire logic [NVEC-1:0]    cq_irq_enable,
  input  wire logic               admin_cq_pending,
  input  wire cq_irq_pkg::qcount_t qcount_in,
  input  wire logic               sq_drained,
  input  wire logic               msg_ready,
  output logic                    msg_valid,
  output logic [4:0]              msg_vector,
  output logic                    irq_wire_n,
  output cq_irq_pkg::qcount_t     qcount_out,
  output logic                    sq_delete_done
);
  import cq_irq_pkg::*;

  initial begin
    if (NVEC < 1 || NVEC > 32) $error("NVEC must be 1..32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [NVEC-1:0] vector_mask_reg;
  logic [31:0]     mode_ctrl_reg;
  logic [31:0]     coal_reg;
  logic [NVEC-1:0] status_vec;
  logic [NVEC-1:0] event_pulse;
  logic [NVEC-1:0] vec_live;
  logic [NVEC-1:0] pend_in;
  irq_mode_t       mode;
  logic            msi_en;
  logic            msix_en;
  logic [2:0]      mme;
  logic            sq_del_req_reg;

  assign msi_en  = mode_ctrl_reg[`BIT_MSI_ENABLE];
  assign msix_en = mode_ctrl_reg[`BIT_MSIX_ENABLE];
  assign mme     = mode_ctrl_reg[`POS_MME_HI:`POS_MME_LO];

  // Unsupported field codes fall back to single MSI rather than guessing
  always_comb begin
    if (msix_en) begin
      mode = MODE_MSIX;
    end else if (!msi_en) begin
      mode = MODE_PIN;
    end else if (mme == 3'h1) begin
      mode = MODE_MSIM;
    end else begin
      mode = MODE_MSI1;
    end
  end

  // Vector 0 only in pin and single MSI, no vector in MSI-X; admin CQ always feeds vector 0
  always_comb begin
    vec_live = (mode == MODE_MSIM) ? '1 : NVEC'(1);
    if (mode == MODE_MSIX) begin
      vec_live = '0;
    end
    pend_in    = cq_pending;
    pend_in[0] = cq_pending[0] | admin_cq_pending;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and messages

  vector_status #(
    .NVEC (NVEC)
  ) u_status (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .cq_pending  (pend_in),
    .vec_irq_en  (cq_irq_enable | NVEC'(admin_cq_pending)),
    .vec_mask    (vector_mask_reg),
    .vec_live    (vec_live),
    .status_reg  (status_vec),
    .event_pulse (event_pulse)
  );

  logic [NVEC-1:0] partial_ack;
  logic [NVEC-1:0] status_d_reg;

  // Some bits fell while others stay set: fresh message on every survivor
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_d_reg <= '0;
    end else begin
      status_d_reg <= status_vec;
    end
  end
  assign partial_ack = ((status_d_reg & ~status_vec) != '0) ? status_vec : '0;

  msg_queue #(
    .NVEC (NVEC)
  ) u_msgq (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .event_pulse    (event_pulse | partial_ack),
    .still_set      (status_vec | event_pulse),
    .msg_mode       (mode == MODE_MSI1 || mode == MODE_MSIM),
    .msg_ready      (msg_ready),
    .msg_valid_reg  (msg_valid),
    .msg_vector_reg (msg_vector)
  );

  // Coalescing is advisory, so no delay is inserted anywhere
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_wire_n <= 1'b1;
    end else begin
      irq_wire_n <= !((mode == MODE_PIN) && status_vec[0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queue-count report and SQ delete completion

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      qcount_out <= '0;
    end else begin
      qcount_out <= qcount_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sq_delete_done <= 1'b0;
    end else begin
      sq_delete_done <= sq_del_req_reg & sq_drained;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        do_write;
  logic [31:0] wmask;

  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wmask    = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg > `OFS_SQ_DELETE) ? 2'b10 : 2'b00;
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Mask set/clear are write-one; simultaneous set and clear of a bit keeps it set
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_mask_reg <= NVEC'(`RST_MASK);
    end else if (do_write && awaddr_reg == `OFS_MASK_SET) begin
      vector_mask_reg <= vector_mask_reg | NVEC'(wdata_reg & wmask);
    end else if (do_write && awaddr_reg == `OFS_MASK_CLEAR) begin
      vector_mask_reg <= vector_mask_reg & ~NVEC'(wdata_reg & wmask);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ctrl_reg <= `RST_MODE_CTRL;
    end else if (do_write && awaddr_reg == `OFS_MODE_CTRL) begin
      mode_ctrl_reg <= (mode_ctrl_reg & ~wmask) | (wdata_reg & wmask);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      coal_reg <= `RST_COAL;
    end else if (do_write && awaddr_reg == `OFS_COAL) begin
      coal_reg <= (coal_reg & ~wmask) | (wdata_reg & wmask);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sq_del_req_reg <= 1'b0;
    end else if (do_write && awaddr_reg == `OFS_SQ_DELETE && wdata_reg[0]) begin
      sq_del_req_reg <= 1'b1;
    end else if (sq_drained) begin
      sq_del_req_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      `OFS_MASK_SET, `OFS_MASK_CLEAR: rd_word = 32'(vector_mask_reg);
      `OFS_MODE_CTRL: rd_word = {mode_ctrl_reg[31:10], mode, mode_ctrl_reg[7:0]};
      `OFS_CQ_ENABLE: rd_word = 32'(cq_irq_enable);
      `OFS_STATUS:    rd_word = 32'(status_vec);
      `OFS_COAL:      rd_word = coal_reg;
      `OFS_QCOUNT:    rd_word = {qcount_out.sq_granted, qcount_out.cq_granted};
      `OFS_SQ_DELETE: rd_word = {sq_delete_done, 30'h0, sq_del_req_reg};
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= (s_axi_araddr > `OFS_SQ_DELETE) ? 2'b10 : 2'b00;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

/* File: tb/cq_irq_props.sv */
// Purpose: Port-level properties of the completion-queue interrupt block.
// Assumes: One clock domain, ref_clk, async active-low reset.
// Notes:   Bound to every cq_irq_ctrl instance.
`timescale 1ns/1ps
module cq_irq_props
  import cq_irq_pkg::*;
#(
  parameter int NVEC = 32
) (
  input wire logic                ref_clk,
  input wire logic                rst_n,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic [NVEC-1:0]     cq_pending,
  input wire logic [NVEC-1:0]     cq_irq_enable,
  input wire logic                admin_cq_pending,
  input wire cq_irq_pkg::qcount_t qcount_in,
  input wire cq_irq_pkg::qcount_t qcount_out,
  input wire logic                sq_drained,
  input wire logic                sq_delete_done,
  input wire logic                msg_ready,
  input wire logic                msg_valid,
  input wire logic [4:0]          msg_vector,
  input wire logic                irq_wire_n
);
  logic [NVEC-1:0] live;
  logic            cause0;
  logic [NVEC-1:0] cause_vec;
  // Admin queue always feeds vector 0 with interrupts on
  assign live   = cq_pending & cq_irq_enable;
  assign cause0 = live[0] | admin_cq_pending;
  assign cause_vec = live | NVEC'(admin_cq_pending);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  property p_wire_cause; !irq_wire_n |-> $past(cause0, 2); endproperty
  a_wire_cause: assert property (p_wire_cause)
    else $error("wire active without a vector 0 cause");
  property p_wire_idle; !cause0 [*3] |-> irq_wire_n; endproperty
  a_wire_idle: assert property (p_wire_idle)
    else $error("wire active with vector 0 idle");
  property p_msg_hold; msg_valid && !msg_ready |=> msg_valid && $stable(msg_vector); endproperty
  a_msg_hold: assert property (p_msg_hold)
    else $error("message request dropped before ready");
  property p_msg_cause;
    $rose(msg_valid) |-> |($past(cause_vec, 2) & (NVEC'(1) << msg_vector));
  endproperty
  a_msg_cause: assert property (p_msg_cause)
    else $error("message for a vector with nothing pending");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response withdrawn");
  property p_read; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_read: assert property (p_read)
    else $error("read answer late");
  property p_qcount; 1'b1 |=> qcount_out == $past(qcount_in); endproperty
  a_qcount: assert property (p_qcount)
    else $error("granted counts not passed on");
  property p_sq_del; $rose(sq_delete_done) |-> $past(sq_drained); endproperty
  a_sq_del: assert property (p_sq_del)
    else $error("deletion reported before drain");
  c_msg: cover property (msg_valid && msg_ready);
  c_wire: cover property ($fell(irq_wire_n));
  c_del: cover property ($rose(sq_delete_done));
endmodule

bind cq_irq_ctrl cq_irq_props #(.NVEC(NVEC)) u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .cq_pending(cq_pending), .cq_irq_enable(cq_irq_enable), .admin_cq_pending(admin_cq_pending),
  .qcount_in(qcount_in), .qcount_out(qcount_out), .sq_drained(sq_drained),
  .sq_delete_done(sq_delete_done), .msg_ready(msg_ready), .msg_valid(msg_valid),
  .msg_vector(msg_vector), .irq_wire_n(irq_wire_n));

/* File: tb/msg_sink.sv */
// Purpose: Message-port model of the host link behind the block.
// Assumes: The block holds each request until it sees msg_ready.
// Notes:   Stall sets how many cycles beyond one a request waits for ready.
`timescale 1ns/1ps
module msg_sink (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       msg_valid,
  input  wire logic [3:0] stall,
  output logic            msg_ready
);
  logic [3:0] wait_reg;
  // Ready is a one-cycle pulse so back-to-back requests each wait
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_ready <= 1'b0;
      wait_reg  <= 4'h0;
    end else if (msg_ready) begin
      msg_ready <= 1'b0;
      wait_reg  <= 4'h0;
    end else if (msg_valid) begin
      msg_ready <= (wait_reg >= stall);
      wait_reg  <= wait_reg + 4'h1;
    end
  end
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the completion-queue interrupt block.
// Assumes: AXI4-Lite master tasks; message port served by msg_sink.
// Notes:   Pin, single and multiple MSI modes; coalescing only read back.
`timescale 1ns/1ps
`include "cq_irq_map.svh"
module testbench;
  import cq_irq_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_bresp;
  logic [31:0] cq_pending = 32'h0, cq_irq_enable = 32'hffff_ffff, seen = 32'h0;
  logic        admin_cq_pending = 1'b0, sq_drained = 1'b0;
  qcount_t     qcount_in = '0, qcount_out;
  logic        msg_ready, msg_valid, irq_wire_n, sq_delete_done;
  logic [4:0]  msg_vector, last_vec = 5'h00;
  logic [3:0]  stall = 4'h0;
  int          msg_cnt = 0, error_cnt = 0, n_tests = 0;

  always #12.5 ref_clk = ~ref_clk;

  cq_irq_ctrl #(.NVEC(32)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cq_pending(cq_pending),
    .cq_irq_enable(cq_irq_enable), .admin_cq_pending(admin_cq_pending),
    .qcount_in(qcount_in), .sq_drained(sq_drained), .msg_ready(msg_ready),
    .msg_valid(msg_valid), .msg_vector(msg_vector), .irq_wire_n(irq_wire_n),
    .qcount_out(qcount_out), .sq_delete_done(sq_delete_done));
  msg_sink u_sink (.ref_clk(ref_clk), .rst_n(rst_n), .msg_valid(msg_valid),
    .stall(stall), .msg_ready(msg_ready));

  // Log of accepted messages
  always @(posedge ref_clk) begin
    if (msg_valid === 1'b1 && msg_ready === 1'b1) begin
      msg_cnt  <= msg_cnt + 1;
      seen     <= seen | (32'h1 << msg_vector);
      last_vec <= msg_vector;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Trailing edge keeps a following call from re-raising valid in the same step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    // Late bready makes every response wait one cycle
    s_axi_bready <= 1'b1;
    @(posedge ref_clk);
    last_bresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, exp, d);
  endtask
  task automatic wchk(input logic exp);
    cyc(3);
    chk("irq_wire_n", {31'h0, exp}, {31'h0, irq_wire_n});
  endtask
  task automatic wmsg(input int n);
    int k;
    k = 0;
    while (msg_cnt < n && k < 300) begin
      @(posedge ref_clk);
      k++;
    end
    chk("msg_cnt", n, msg_cnt);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    logic [31:0] mv [4] = '{32'h0, 32'h1, 32'h11, 32'h2};
    rchk("mask_reset", `OFS_MASK_SET, `RST_MASK);
    rchk("coal_reset", `OFS_COAL, `RST_COAL);
    wr(`OFS_MASK_SET, 32'h0000_0088);
    wr(`OFS_MASK_CLEAR, 32'h0000_0080);
    rchk("mask", `OFS_MASK_CLEAR, 32'h0000_0008);
    wr(`OFS_MASK_CLEAR, 32'h0000_0008);
    wr(`OFS_COAL, 32'h0a0b_0c0d);
    chk("coal_bresp", 32'h0, {30'h0, last_bresp});
    rchk("coal", `OFS_COAL, 32'h0a0b_0c0d);
    rchk("cq_en", `OFS_CQ_ENABLE, cq_irq_enable);
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_MODE_CTRL, mv[i]);
      rd(`OFS_MODE_CTRL, d, r);
      chk("mode", i, {30'h0, d[9:8]});
    end
    rd(8'h20, d, r);
    chk("unmapped_resp", 32'h2, {30'h0, r});
    chk("unmapped_data", 32'h0, d);
    wr(8'h20, 32'hffff_ffff);
    chk("unmapped_bresp", 32'h2, {30'h0, last_bresp});
  endtask
  task automatic t_pin();
    int n;
    n = msg_cnt;
    wr(`OFS_MODE_CTRL, 32'h0);
    cq_irq_enable <= 32'h0;
    cq_pending    <= 32'h1;
    wchk(1'b1);
    cq_irq_enable <= 32'hffff_ffff;
    wchk(1'b0);
    rchk("status", `OFS_STATUS, 32'h1);
    wr(`OFS_MASK_SET, 32'h1);
    wchk(1'b1);
    wr(`OFS_MASK_CLEAR, 32'h1);
    wchk(1'b0);
    cq_pending <= 32'h2;
    wchk(1'b1);
    admin_cq_pending <= 1'b1;
    wchk(1'b0);
    admin_cq_pending <= 1'b0;
    cq_pending       <= 32'h0;
    wchk(1'b1);
    chk("pin_msgs", n, msg_cnt);
  endtask
  task automatic t_msi();
    int n;
    wr(`OFS_MODE_CTRL, 32'h11);
    stall      <= 4'h3;
    n          = msg_cnt;
    cq_pending <= 32'h28;
    wmsg(n + 2);
    chk("vecs", 32'h28, seen);
    wr(`OFS_MASK_SET, 32'h80);
    cq_pending <= 32'ha8;
    cyc(20);
    chk("masked", n + 2, msg_cnt);
    wr(`OFS_MASK_CLEAR, 32'h80);
    wmsg(n + 3);
    chk("unmask_vec", 32'h7, {27'h0, last_vec});
    cq_pending <= 32'ha0;
    wmsg(n + 4);
    cyc(20);
    chk("requeue", n + 5, msg_cnt);
    n          = msg_cnt;
    cq_pending <= 32'h0;
    cyc(20);
    chk("idle_msgs", n, msg_cnt);
    wr(`OFS_MODE_CTRL, 32'h1);
    stall      <= 4'h0;
    cq_pending <= 32'h2;
    cyc(20);
    chk("single_vec1", n, msg_cnt);
    cq_pending <= 32'h3;
    wmsg(n + 1);
    chk("single_vec", 32'h0, {27'h0, last_vec});
    wr(`OFS_MODE_CTRL, 32'h2);
    cyc(20);
    chk("msix_msgs", n + 1, msg_cnt);
    chk("msix_wire", 32'h1, {31'h0, irq_wire_n});
    cq_pending <= 32'h0;
    cyc(5);
  endtask
  task automatic t_misc();
    qcount_in <= '{req: 1'b1, sq_granted: 16'h0007, cq_granted: 16'h0005};
    cyc(2);
    chk("qc_req", 32'h1, {31'h0, qcount_out.req});
    chk("qc_sq", 32'h7, {16'h0, qcount_out.sq_granted});
    chk("qc_cq", 32'h5, {16'h0, qcount_out.cq_granted});
    rchk("qcount", `OFS_QCOUNT, 32'h0007_0005);
    wr(`OFS_SQ_DELETE, 32'h1);
    cyc(5);
    chk("del_early", 32'h0, {31'h0, sq_delete_done});
    sq_drained <= 1'b1;
    cyc(1);
    #1;
    chk("del_done", 32'h1, {31'h0, sq_delete_done});
    @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_pin();
    t_msi();
    t_misc();
    report_and_stop();
  end
  // Whole run needs about three hundred cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
